// >>> inc/etsp_pkg.sv
// package: register map, field positions, reset values and timing for the event timer
package etsp_pkg;
	localparam logic [7:0] ADDR_TIMER_COUNT = 8'h01;
	localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h0B;
	localparam logic [7:0] ADDR_TIMER_PRESCALE_CONFIG = 8'h81;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'hC0;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hC1;
	localparam int POS_COUNT_SOURCE = 5;
	localparam int POS_COUNT_EDGE = 4;
	localparam int POS_OWNER = 3;
	localparam int POS_OVF_ENABLE = 5;
	localparam int POS_OVF_FLAG = 2;
	localparam int IRQ_BIT_OVF = 0;
	localparam int IRQ_BIT_WDT = 1;
	localparam logic [7:0] CONFIG_RESET = 8'hFF;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] INTCTL_RESET = 8'h00;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;
	// instruction cycle is four system clocks: phases one to four
	localparam int PHASE_COUNT = 4;
	localparam logic [1:0] PHASE_TWO = 2'h1;
	localparam logic [1:0] PHASE_FOUR = 2'h3;
	localparam logic [1:0] PHASE_RESET = 2'h0;
	localparam logic [7:0] PRESCALE_RESET = 8'h00;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} etsp_bus_req_t;

	typedef struct packed {
		logic count_source_select;
		logic count_edge_select;
		logic prescaler_owner_select;
		logic [2:0] prescale_rate_field;
	} etsp_cfg_t;
endpackage

// >>> logic/etsp_edge_sync.sv
// pin synchroniser sampled on phase two and phase four, with edge detect
`timescale 1ns/10ps
module etsp_edge_sync (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// control
	input wire logic phase_sample_in,
	input wire logic falling_in,
	// pin and event
	input wire logic pin_in,
	output logic edge_out
);
	logic meta_reg;
	logic sync_reg;
	logic sample_reg;
	logic prev_reg;
	logic sample_next;
	wire rise = sample_reg & ~prev_reg;
	wire fall = ~sample_reg & prev_reg;

	// the sample is taken only on phase two and phase four strobes
	assign sample_next = phase_sample_in ? sync_reg : sample_reg;
	assign edge_out = falling_in ? fall : rise;

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			sample_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			sample_reg <= sample_next;
			prev_reg <= sample_reg;
		end
	end

	a_edge_single: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		edge_out |=> !edge_out)
		else $error("edge held two cycles");
endmodule

// >>> logic/etsp_prescaler.sv
// shared prescaler: 8-bit hidden count, one tick per programmed ratio
`timescale 1ns/10ps
module etsp_prescaler (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// control
	input wire logic clear_in,
	input wire logic step_in,
	input wire logic [7:0] ratio_m1_in,
	// output
	output logic tick_out
);
	logic [7:0] count_reg;
	logic [7:0] count_next;
	wire at_end = (count_reg >= ratio_m1_in);

	// count has no bus path; only clear and step touch it
	assign count_next = clear_in ? etsp_pkg::PRESCALE_RESET :
		!step_in ? count_reg :
		at_end ? etsp_pkg::PRESCALE_RESET : count_reg + 8'h01;
	assign tick_out = step_in & at_end & ~clear_in;

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in)
			count_reg <= etsp_pkg::PRESCALE_RESET;
		else
			count_reg <= count_next;
	end

	a_tick_ratio: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		tick_out |-> count_reg >= ratio_m1_in)
		else $error("tick early");
endmodule

// >>> logic/etsp_timer.sv
// event timer top: 8-bit counter, shared prescaler, register port, interrupt
`timescale 1ns/10ps
module etsp_timer (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// core events
	input wire logic watchdog_clear_instruction_in,
	input wire logic sleep_in,
	input wire logic wdt_base_tick_in,
	// pin
	input wire logic external_count_pin_in,
	// outputs
	output logic watchdog_tick_out,
	output logic irq_out
);
	etsp_pkg::etsp_bus_req_t req;
	etsp_pkg::etsp_cfg_t cfg;
	logic [7:0] config_reg;
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic [7:0] intctl_reg;
	logic [7:0] intctl_next;
	logic [1:0] status_reg;
	logic [1:0] status_next;
	logic [1:0] mask_reg;
	logic [1:0] phase_reg;
	logic [1:0] inhibit_reg;
	logic [1:0] inhibit_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic pin_edge;
	logic pre_tick;
	logic [7:0] ratio_m1;

	assign req = '{addr: reg_addr_in, wdata: reg_wdata_in,
		wr: reg_wr_in, rd: reg_rd_in};
	assign cfg = '{count_source_select: config_reg[etsp_pkg::POS_COUNT_SOURCE],
		count_edge_select: config_reg[etsp_pkg::POS_COUNT_EDGE],
		prescaler_owner_select: config_reg[etsp_pkg::POS_OWNER],
		prescale_rate_field: config_reg[2:0]};

	// address decode
	wire sel_count = req.addr == etsp_pkg::ADDR_TIMER_COUNT;
	wire sel_intctl = req.addr == etsp_pkg::ADDR_INTERRUPT_CONTROL;
	wire sel_config = req.addr == etsp_pkg::ADDR_TIMER_PRESCALE_CONFIG;
	wire sel_status = req.addr == etsp_pkg::ADDR_IRQ_STATUS;
	wire sel_mask = req.addr == etsp_pkg::ADDR_IRQ_MASK;
	wire wr_count = req.wr & sel_count;
	wire wr_intctl = req.wr & sel_intctl;
	wire wr_config = req.wr & sel_config;
	wire wr_status = req.wr & sel_status;
	wire wr_mask = req.wr & sel_mask;

	// instruction cycle phases
	wire phase_two = phase_reg == etsp_pkg::PHASE_TWO;
	wire phase_four = phase_reg == etsp_pkg::PHASE_FOUR;
	wire cycle_end = phase_four;
	wire owner_wdt = cfg.prescaler_owner_select;
	wire owner_tmr = ~owner_wdt;

	// timer ratio 2^(n+1); watchdog half of it, so 000 gives 1:1
	assign ratio_m1 = owner_tmr ?
		8'((9'h002 << cfg.prescale_rate_field) - 9'h001) :
		8'((9'h001 << cfg.prescale_rate_field) - 9'h001);

	// raw source of the timer path: pin edge or instruction cycle
	wire tmr_src = cfg.count_source_select ? pin_edge : cycle_end;
	wire awake = ~sleep_in;
	// the prescaler steps on its owner's source; only the timer side stops
	// in sleep, the watchdog must keep running to wake the core
	wire pre_step = owner_tmr ? (awake & tmr_src) :
		wdt_base_tick_in;
	// clearing by count writes leaves config untouched
	wire pre_clear = (owner_tmr & wr_count) |
		(owner_wdt & watchdog_clear_instruction_in);
	wire tmr_tick = awake & (owner_tmr ? pre_tick : tmr_src);
	assign watchdog_tick_out = owner_wdt ? pre_tick : wdt_base_tick_in;

	etsp_edge_sync u_sync (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.phase_sample_in(phase_two | phase_four),
		.falling_in(cfg.count_edge_select),
		.pin_in(external_count_pin_in),
		.edge_out(pin_edge)
	);

	etsp_prescaler u_pre (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.clear_in(pre_clear),
		.step_in(pre_step),
		.ratio_m1_in(ratio_m1),
		.tick_out(pre_tick)
	);

	// counting with write inhibit for two instruction cycles
	wire inhibited = inhibit_reg != 2'h0;
	wire do_inc = tmr_tick & ~inhibited & ~wr_count;
	wire overflow = do_inc & (count_reg == 8'hFF);
	assign count_next = wr_count ? req.wdata :
		do_inc ? count_reg + 8'h01 : count_reg;
	assign inhibit_next = wr_count ? etsp_pkg::WRITE_INHIBIT_CYCLES :
		(inhibited & cycle_end) ? inhibit_reg - 2'h1 : inhibit_reg;

	// hardware set wins over a software write to the flag
	always_comb begin
		intctl_next = wr_intctl ? req.wdata : intctl_reg;
		if (overflow)
			intctl_next[etsp_pkg::POS_OVF_FLAG] = 1'b1;
	end

	wire [1:0] irq_events = {watchdog_tick_out, overflow};
	assign status_next = (status_reg & ~(wr_status ? req.wdata[1:0] : 2'h0))
		| irq_events;
	assign irq_out = |(status_reg & mask_reg) |
		(intctl_reg[etsp_pkg::POS_OVF_FLAG] &
		intctl_reg[etsp_pkg::POS_OVF_ENABLE]);

	// read mux; unmapped addresses read zero; prescaler count is absent
	assign rdata_next = !req.rd ? 8'h00 :
		sel_count ? count_reg :
		sel_intctl ? intctl_reg :
		sel_config ? config_reg :
		sel_status ? {6'h00, status_reg} :
		sel_mask ? {6'h00, mask_reg} : 8'h00;
	assign reg_rdata_out = rdata_reg;

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			phase_reg <= etsp_pkg::PHASE_RESET;
			config_reg <= etsp_pkg::CONFIG_RESET;
			count_reg <= etsp_pkg::COUNT_RESET;
			intctl_reg <= etsp_pkg::INTCTL_RESET;
			status_reg <= etsp_pkg::IRQ_RESET;
			mask_reg <= etsp_pkg::IRQ_RESET;
			inhibit_reg <= 2'h0;
			rdata_reg <= 8'h00;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			if (wr_config)
				config_reg <= req.wdata;
			count_reg <= count_next;
			intctl_reg <= intctl_next;
			status_reg <= status_next;
			if (wr_mask)
				mask_reg <= req.wdata[1:0];
			inhibit_reg <= inhibit_next;
			rdata_reg <= rdata_next;
		end
	end

	a_overflow_flag: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		overflow |=> intctl_reg[etsp_pkg::POS_OVF_FLAG] && count_reg == 8'h00)
		else $error("overflow did not set flag");
	a_write_inhibit: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		wr_count ##1 !wr_count [*7] |=> count_reg == $past(count_reg, 7))
		else $error("count moved during inhibit");
	a_sleep_stop: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		sleep_in && !wr_count |=> count_reg == $past(count_reg))
		else $error("count moved in sleep");
	a_cfg_kept: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		wr_count && !wr_config |=> $stable(config_reg))
		else $error("count write changed config");
	a_clear_owner: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		owner_tmr && wr_count |=> u_pre.count_reg == etsp_pkg::PRESCALE_RESET)
		else $error("count write missed prescaler clear");
	a_wdt_clear: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		owner_wdt && watchdog_clear_instruction_in |=>
		u_pre.count_reg == etsp_pkg::PRESCALE_RESET)
		else $error("watchdog clear missed prescaler");
	a_wdt_undiv: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		owner_tmr |-> watchdog_tick_out == wdt_base_tick_in)
		else $error("watchdog divided without owning");
	a_ratio_unity: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		owner_wdt && cfg.prescale_rate_field == 3'h0 |-> ratio_m1 == 8'h00)
		else $error("watchdog 000 not 1:1");
	a_read_late: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		req.rd && sel_config && !wr_config |=> reg_rdata_out == config_reg)
		else $error("read data wrong");
	a_count_load: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		wr_count |=> count_reg == $past(req.wdata))
		else $error("count write did not land");
	a_count_step: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		!wr_count |=> count_reg == $past(count_reg) ||
		count_reg == 8'($past(count_reg) + 8'h01))
		else $error("count jumped");
	a_internal_rate: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		owner_wdt && !cfg.count_source_select && awake && cycle_end &&
		!inhibited && !wr_count |=> count_reg == 8'($past(count_reg) + 8'h01))
		else $error("instruction cycle not counted");
	a_internal_idle: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		!cfg.count_source_select && !cycle_end && !wr_count |=>
		$stable(count_reg))
		else $error("count moved inside instruction cycle");
	a_inhibit_load: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		wr_count |=> inhibit_reg == etsp_pkg::WRITE_INHIBIT_CYCLES)
		else $error("write inhibit not armed");
	a_phase_wrap: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		phase_four |=> phase_reg == etsp_pkg::PHASE_RESET)
		else $error("phase counter did not wrap");
	a_pin_only: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		cfg.count_source_select && !pin_edge && !wr_count |=>
		$stable(count_reg))
		else $error("counter mode moved without pin edge");
	a_pin_counts: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		owner_wdt && cfg.count_source_select && pin_edge && awake &&
		!inhibited && !wr_count |=> count_reg == 8'($past(count_reg) + 8'h01))
		else $error("pin edge not counted");
	a_pre_restart: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		pre_tick |=> u_pre.count_reg == etsp_pkg::PRESCALE_RESET)
		else $error("prescaler did not restart");
	a_pre_hold: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		!pre_step && !pre_clear |=> $stable(u_pre.count_reg))
		else $error("prescaler moved without step");
	a_pre_sleep: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		sleep_in && owner_tmr && !wr_count |=> $stable(u_pre.count_reg))
		else $error("timer prescaler moved in sleep");
	a_wdt_owned: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		owner_wdt && !wdt_base_tick_in |-> !watchdog_tick_out)
		else $error("watchdog tick without base tick");
	a_wdt_sleep_run: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		owner_wdt && sleep_in && wdt_base_tick_in &&
		cfg.prescale_rate_field == 3'h0 && !watchdog_clear_instruction_in
		|-> watchdog_tick_out)
		else $error("watchdog stopped in sleep");
	a_ratio_top: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		owner_tmr && cfg.prescale_rate_field == 3'h7 |-> ratio_m1 == 8'hFF)
		else $error("timer 111 not 1:256");
	a_ratio_half: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		owner_wdt && cfg.prescale_rate_field == 3'h7 |-> ratio_m1 == 8'h7F)
		else $error("watchdog 111 not 1:128");
	a_ratio_low: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		owner_tmr && cfg.prescale_rate_field == 3'h0 |-> ratio_m1 == 8'h01)
		else $error("timer 000 not 1:2");
	a_config_load: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		wr_config |=> config_reg == $past(req.wdata))
		else $error("config write did not land");
	a_status_set: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		overflow |=> status_reg[etsp_pkg::IRQ_BIT_OVF])
		else $error("overflow did not set status");
	a_status_clear: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		wr_status && req.wdata[etsp_pkg::IRQ_BIT_OVF] && !overflow |=>
		!status_reg[etsp_pkg::IRQ_BIT_OVF])
		else $error("status bit not cleared");
	a_flag_sticky: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		intctl_reg[etsp_pkg::POS_OVF_FLAG] && !wr_intctl |=>
		intctl_reg[etsp_pkg::POS_OVF_FLAG])
		else $error("overflow flag dropped");
	a_irq_enable: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		intctl_reg[etsp_pkg::POS_OVF_FLAG] &&
		intctl_reg[etsp_pkg::POS_OVF_ENABLE] |-> irq_out)
		else $error("enabled flag gave no request");
	a_irq_quiet: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		!intctl_reg[etsp_pkg::POS_OVF_ENABLE] && mask_reg == 2'h0 |-> !irq_out)
		else $error("masked request raised");
	a_read_hidden: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in)
		req.rd && !(sel_count || sel_intctl || sel_config || sel_status ||
		sel_mask) |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");

	c_overflow: cover property (@(posedge clk_sys_in) overflow);
	c_pin_edge: cover property (@(posedge clk_sys_in) pin_edge && tmr_tick);
	c_wdt_tick: cover property (@(posedge clk_sys_in) owner_wdt && pre_tick);
	c_irq: cover property (@(posedge clk_sys_in) irq_out);
	c_inhibit: cover property (@(posedge clk_sys_in) wr_count ##1 inhibited);
endmodule

// >>> tb/etsp_pin_source.sv
// external count source: drives whole pulses onto the count pin
`timescale 1ns/10ps
module etsp_pin_source (
	// clock
	input wire logic clk_sys_in,
	// pin
	output logic pin_out
);
	initial pin_out = 1'b0;
	// each level is held at least three clocks, above the two-clock minimum
	task automatic burst(input int n, input int hold);
		repeat (n) begin
			repeat (hold) @(posedge clk_sys_in);
			pin_out <= 1'b1;
			repeat (hold) @(posedge clk_sys_in);
			pin_out <= 1'b0;
		end
	endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the event timer with shared prescaler
`timescale 1ns/10ps
module testbench;
	logic clk_sys_in, rstn_in, reg_wr_in, reg_rd_in, wdc_in, sleep_in;
	logic base_in, pin, watchdog_tick_out, irq_out;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rd_val;
	int bad_count, check_count, wd_ticks, w0;

	etsp_timer dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out),
		.watchdog_clear_instruction_in(wdc_in), .sleep_in(sleep_in),
		.wdt_base_tick_in(base_in), .external_count_pin_in(pin),
		.watchdog_tick_out(watchdog_tick_out), .irq_out(irq_out));
	etsp_pin_source src (.clk_sys_in(clk_sys_in), .pin_out(pin));

	initial begin
		clk_sys_in = 1'b0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) begin
		if (watchdog_tick_out === 1'b1) wd_ticks++;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic chkr(input logic [7:0] s, lo, hi);
		chk((s >= lo && s <= hi) ? 8'h01 : 8'h00, 8'h01);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		#1 rd_val = reg_rdata_out;
	endtask
	task automatic irq_is(input logic e);
		#1 chk({7'h00, irq_out}, {7'h00, e});
	endtask
	task automatic wd_clear;
		@(posedge clk_sys_in);
		wdc_in <= 1'b1;
		@(posedge clk_sys_in);
		wdc_in <= 1'b0;
	endtask
	task automatic base(input int n);
		repeat (n) begin
			@(posedge clk_sys_in);
			base_in <= 1'b1;
			@(posedge clk_sys_in);
			base_in <= 1'b0;
			tick(2);
		end
		#1;
	endtask
	// move the prescaler from timer to watchdog in the safe order
	task automatic to_wdt(input logic [7:0] c);
		wr(8'h81, (c & 8'hF0) | 8'h01);
		wr(8'h01, 8'h00);
		wr(8'h81, (c & 8'hF0) | 8'h09);
		wd_clear();
		wr(8'h81, c);
	endtask
	// move the prescaler from watchdog to timer: watchdog clear first
	task automatic to_tmr(input logic [7:0] c);
		wd_clear();
		wr(8'h81, c);
	endtask

	task automatic t_reset;
		rd(8'h81);
		chk(rd_val, 8'hFF);
		rd(8'h01);
		chk(rd_val, 8'h00);
		rd(8'h0B);
		chk(rd_val, 8'h00);
		rd(8'h02);
		chk(rd_val, 8'h00);
	endtask
	task automatic t_internal;
		wr(8'h81, 8'h08);
		wr(8'h01, 8'h00);
		tick(40);
		rd(8'h01);
		chkr(rd_val, 8'h07, 8'h09);
		wr(8'h01, 8'h00);
		sleep_in <= 1'b1;
		tick(40);
		rd(8'h01);
		chk(rd_val, 8'h00);
		sleep_in <= 1'b0;
	endtask
	task automatic t_ratio;
		for (int r = 0; r < 3; r++) begin
			to_tmr(8'(r));
			wr(8'h01, 8'h00);
			tick(40 << r);
			rd(8'h01);
			chkr(rd_val, 8'h04, 8'h05);
			rd(8'h81);
			chk(rd_val, 8'(r));
		end
	endtask
	task automatic t_pin;
		to_wdt(8'h28);
		wr(8'h01, 8'h00);
		tick(8);
		src.burst(5, 6);
		tick(10);
		rd(8'h01);
		chk(rd_val, 8'h05);
		wr(8'h81, 8'h38);
		wr(8'h01, 8'h00);
		tick(8);
		src.burst(3, 3);
		tick(10);
		rd(8'h01);
		chk(rd_val, 8'h03);
		to_tmr(8'h20);
		wr(8'h01, 8'h00);
		tick(8);
		src.burst(8, 12);
		tick(10);
		rd(8'h01);
		chk(rd_val, 8'h04);
	endtask
	task automatic t_irq;
		to_wdt(8'h08);
		wr(8'hC1, 8'h00);
		wr(8'h01, 8'hFE);
		tick(30);
		rd(8'h0B);
		chk(rd_val, 8'h04);
		irq_is(1'b0);
		rd(8'hC0);
		chk(rd_val & 8'h01, 8'h01);
		wr(8'hC1, 8'h01);
		irq_is(1'b1);
		wr(8'hC0, 8'h01);
		irq_is(1'b0);
		rd(8'hC0);
		chk(rd_val & 8'h01, 8'h00);
		wr(8'h0B, 8'h24);
		irq_is(1'b1);
		wr(8'h0B, 8'h20);
		irq_is(1'b0);
	endtask
	task automatic t_wdt;
		wr(8'h81, 8'h08);
		w0 = wd_ticks;
		base(6);
		chk(8'(wd_ticks - w0), 8'h06);
		wr(8'h81, 8'h09);
		wd_clear();
		w0 = wd_ticks;
		base(6);
		chk(8'(wd_ticks - w0), 8'h03);
		w0 = wd_ticks;
		base(1);
		wd_clear();
		base(1);
		chk(8'(wd_ticks - w0), 8'h00);
		to_tmr(8'h01);
		w0 = wd_ticks;
		base(4);
		chk(8'(wd_ticks - w0), 8'h04);
	endtask

	task automatic close_out;
		if (bad_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		rstn_in = 1'b0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 8'h00;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		wdc_in = 1'b0;
		sleep_in = 1'b0;
		base_in = 1'b0;
		tick(3);
		rstn_in <= 1'b1;
		t_reset();
		t_internal();
		t_ratio();
		t_pin();
		t_irq();
		t_wdt();
		close_out();
	end
	initial begin
		tick(20000);
		bad_count++;
		close_out();
	end
endmodule
